// [common/olmc_consts.svh]
// olmc_consts.svh: register indices, field positions, reset values and timing for the loopback/mono block
// assumes: included by bare name; byte address of a register is four times its index
`ifndef OLMC_CONSTS_SVH
`define OLMC_CONSTS_SVH
// ----------------------------------------
// register indices
// ----------------------------------------
`define OLMC_IDX_ACC_DET 12'h293
`define OLMC_IDX_PATH1 12'h410
`define OLMC_IDX_PATH2 12'h418
`define OLMC_IDX_PATH3 12'h420
`define OLMC_IDX_GSEL_BASE 12'h413
`define OLMC_IDX_GSEL_STEP 12'h004
`define OLMC_IDX_LOOP1 12'h450
`define OLMC_IDX_LOOP2 12'h451
`define OLMC_IDX_GATE_CTRL 12'h458
`define OLMC_IDX_STATUS 12'h459
// ----------------------------------------
// field positions
// ----------------------------------------
`define OLMC_BIT_DET_SEL 13
`define OLMC_BIT_MONO 12
`define OLMC_BIT_LOOP_ON 0
`define OLMC_BIT_LOOP_ACT 1
`define OLMC_LSB_LOOP_SRC 2
`define OLMC_BIT_GATE_ON 0
`define OLMC_LSB_GATE_THR 1
`define OLMC_LSB_GATE_HOLD 4
`define OLMC_BIT_UNDERCLK 0
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define OLMC_RST_SRC 4'h0
`define OLMC_LOOP_MIN_CYC 64
`define OLMC_CLK_KHZ 250000
`define OLMC_HOLD0_MS 30
`define OLMC_HOLD1_MS 120
`define OLMC_HOLD2_MS 250
`define OLMC_HOLD3_MS 500
`endif

// [common/olmc_pkg.sv]
// olmc_pkg.sv: types shared by the loopback/mono block
// assumes: referenced as olmc_pkg::name, never imported
package olmc_pkg;
  // loopback source codes, 0101 and 1100..1111 are reserved
  typedef enum logic [3:0] {
    OLMC_SRC_P1L = 4'h0, OLMC_SRC_P1R = 4'h1, OLMC_SRC_P2L = 4'h2, OLMC_SRC_P2R = 4'h3,
    OLMC_SRC_P3 = 4'h4, OLMC_SRC_P4L = 4'h6, OLMC_SRC_P4R = 4'h7, OLMC_SRC_P5L = 4'h8,
    OLMC_SRC_P5R = 4'h9, OLMC_SRC_P6L = 4'ha, OLMC_SRC_P6R = 4'hb
  } olmc_src_t;
  typedef logic [1:0] olmc_hold_t;
endpackage

// [hw/olmc_top.sv]
// olmc_top.sv: echo-reference loopback, headphone mono mode, noise gates and detect-pin select
// assumes: APB master on core_clk_in; path samples are post-volume and arrive with one strobe per frame
// Function
// - global gate enable bit zero gates everything
// - gate mutes only when all sources quiet
// - hold delay 30/120/250/500 ms before muting
// - two independent loopbacks, any output path
// - loopback taps after digital volume
// - loopbacks go to mixers at output rate
// - 4-bit source select at bits 5:2
// - enable request bit 0 per loopback
// - too few clock cycles refuses enable, error
// - refused enable leaves running paths alone
// - read-only active status at bit 1
// - mono bit 12 drives right as inverted left
// - mono mode doubles swing, plus 6 dB
// - bit 13 picks detect and feedback pins
// - paths 1-3 drive headphones 1-3
// - path 4 feeds speaker drivers
`timescale 1ns/1ps
`include "olmc_consts.svh"
module olmc_top #(
  parameter int SAMPLE_W = 24,                          // sample width
  parameter int LOOP_MIN_CYCLES = `OLMC_LOOP_MIN_CYC,   // least clocks per frame for loopback
  parameter int HOLD0_CYC = `OLMC_HOLD0_MS * `OLMC_CLK_KHZ,
  parameter int HOLD1_CYC = `OLMC_HOLD1_MS * `OLMC_CLK_KHZ,
  parameter int HOLD2_CYC = `OLMC_HOLD2_MS * `OLMC_CLK_KHZ,
  parameter int HOLD3_CYC = `OLMC_HOLD3_MS * `OLMC_CLK_KHZ
) (
  input wire logic core_clk_in,                            // system clock, 250 MHz
  input wire logic rst_b_in,                               // async reset, active low
  input wire logic psel_in,                                // apb select
  input wire logic penable_in,                             // apb enable
  input wire logic pwrite_in,                              // apb direction
  input wire logic [15:0] paddr_in,                        // apb byte address
  input wire logic [31:0] pwdata_in,                       // apb write data
  output logic pready_out,                                 // apb ready
  output logic pslverr_out,                                // apb error, unmapped
  output logic [31:0] prdata_out,                          // apb read data
  input wire logic [11:0][SAMPLE_W-1:0] path_sample_in,    // post-volume samples 1L..6R
  input wire logic sample_strobe_in,                       // one pulse per output frame
  input wire logic [11:0] path_below_thr_in,               // level below gate threshold
  output logic [SAMPLE_W-1:0] echo_ref1_data_out,          // loopback 1 stream
  output logic [SAMPLE_W-1:0] echo_ref2_data_out,          // loopback 2 stream
  output logic echo_ref_strobe_out,                        // loopback frame strobe
  output logic [2:0][SAMPLE_W-1:0] hp_left_out,            // headphone 1..3 left
  output logic [2:0][SAMPLE_W-1:0] hp_right_out,           // headphone 1..3 right
  output logic [SAMPLE_W-1:0] spk_left_out,                // speaker left
  output logic [SAMPLE_W-1:0] spk_right_out,               // speaker right
  output logic [11:0] gate_mute_out,                       // per-path gate mute
  output logic [2:0] hp_differential_out,                  // mono mode flags to drivers
  output logic [2:0] gate_threshold_out,                   // threshold code to level detectors
  output logic detect_pin_set_sel_out,                     // 0: pin a set, 1: pin b set
  output logic echo_ref1_active_out,                       // loopback 1 running
  output logic echo_ref2_active_out,                       // loopback 2 running
  output logic underclk_err_out                            // sticky underclock error
);
  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (SAMPLE_W < 2 || SAMPLE_W > 32 || LOOP_MIN_CYCLES < 1 || HOLD0_CYC < 1) begin : g_bad
    $error("olmc_top: unsupported parameter value");
  end

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  logic pready_q;            // ready, one wait state
  logic pslverr_q;           // error flag
  logic [31:0] prdata_q;     // captured read data
  logic [31:0] rdata_d;      // read mux
  logic hit_d;               // address mapped
  logic [11:0] idx;          // register index
  logic acc_ph;              // access phase, not yet ready
  logic wr;                  // write takes effect
  assign idx = paddr_in[13:2];
  assign acc_ph = psel_in & penable_in & ~pready_q;
  assign wr = psel_in & penable_in & pready_q & pwrite_in & hit_d;

  // ready one cycle into access, data and error captured then
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= acc_ph;
      pslverr_q <= acc_ph & ~hit_d;
      if (acc_ph && !pwrite_in) begin
        prdata_q <= rdata_d;
      end
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  logic det_sel_q;                 // detect pin set
  logic [2:0] mono_q;              // headphone mono flags
  logic gate_on_q;                 // global gate enable
  logic [2:0] gate_thr_q;          // gate threshold code
  olmc_pkg::olmc_hold_t hold_q;    // hold delay code
  logic err_q;                     // underclock error
  logic [3:0] src_q [2];           // loopback source codes
  logic [1:0] on_q;                // loopback requests
  logic [1:0] act_q;               // loopback running
  logic [1:0] rej;                 // refused enable this cycle
  logic [11:0] gsel_q [12];        // gate source masks
  logic [31:0] hold_lim;           // current hold count

  // plain fields
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      det_sel_q <= 1'b0;
      mono_q <= 3'h0;
      gate_on_q <= 1'b0;
      gate_thr_q <= 3'h0;
      hold_q <= 2'h0;
    end else if (wr) begin
      case (idx)
        `OLMC_IDX_ACC_DET: det_sel_q <= pwdata_in[`OLMC_BIT_DET_SEL];
        `OLMC_IDX_PATH1: mono_q[0] <= pwdata_in[`OLMC_BIT_MONO];
        `OLMC_IDX_PATH2: mono_q[1] <= pwdata_in[`OLMC_BIT_MONO];
        `OLMC_IDX_PATH3: mono_q[2] <= pwdata_in[`OLMC_BIT_MONO];
        `OLMC_IDX_GATE_CTRL: begin
          gate_on_q <= pwdata_in[`OLMC_BIT_GATE_ON];
          gate_thr_q <= pwdata_in[`OLMC_LSB_GATE_THR +: 3];
          hold_q <= pwdata_in[`OLMC_LSB_GATE_HOLD +: 2];
        end
        default: begin
        end
      endcase
    end
  end

  // sticky error, a new refusal wins over a clear
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      err_q <= 1'b0;
    end else begin
      err_q <= (err_q & ~(wr && idx == `OLMC_IDX_STATUS && pwdata_in[`OLMC_BIT_UNDERCLK])) | (|rej);
    end
  end

  // ----------------------------------------
  // clock budget per frame
  // ----------------------------------------
  logic [15:0] per_cnt_q;    // clocks since last strobe, saturating
  logic budget_ok_q;         // last frame had enough clocks

  // count clocks between frame strobes
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      per_cnt_q <= 16'h0;
      budget_ok_q <= 1'b0;
    end else if (sample_strobe_in) begin
      per_cnt_q <= 16'h0;
      budget_ok_q <= (32'(per_cnt_q) + 32'd1) >= 32'(LOOP_MIN_CYCLES);
    end else if (per_cnt_q != 16'hffff) begin
      per_cnt_q <= per_cnt_q + 16'h1;
    end
  end

  // ----------------------------------------
  // loopback paths
  // ----------------------------------------
  // pick a post-volume sample, reserved codes give silence
  function automatic logic [SAMPLE_W-1:0] pick(input logic [3:0] code,
                                               input logic [11:0][SAMPLE_W-1:0] s);
    logic [SAMPLE_W-1:0] r;
    r = '0;
    if (code <= 4'h4) begin
      r = s[code];
    end else if (code >= 4'h6 && code <= 4'hb) begin
      r = s[code];
    end
    return r;
  endfunction

  for (genvar g = 0; g < 2; g++) begin : g_loop
    logic hit_l;   // write to this loopback register
    assign hit_l = wr && idx == (g == 0 ? `OLMC_IDX_LOOP1 : `OLMC_IDX_LOOP2);
    assign rej[g] = hit_l & pwdata_in[`OLMC_BIT_LOOP_ON] & ~act_q[g] & ~budget_ok_q;

    // request, source and status; status bit itself is not writable
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        on_q[g] <= 1'b0;
        act_q[g] <= 1'b0;
        src_q[g] <= `OLMC_RST_SRC;
      end else if (hit_l) begin
        on_q[g] <= pwdata_in[`OLMC_BIT_LOOP_ON];
        src_q[g] <= pwdata_in[`OLMC_LSB_LOOP_SRC +: 4];
        if (!pwdata_in[`OLMC_BIT_LOOP_ON]) begin
          act_q[g] <= 1'b0;
        end else if (!act_q[g]) begin
          act_q[g] <= budget_ok_q;
        end
      end
    end
  end

  // loopback streams at the output-path frame rate
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      echo_ref1_data_out <= '0;
      echo_ref2_data_out <= '0;
      echo_ref_strobe_out <= 1'b0;
    end else begin
      echo_ref_strobe_out <= sample_strobe_in;
      if (sample_strobe_in) begin
        echo_ref1_data_out <= act_q[0] ? pick(src_q[0], path_sample_in) : '0;
        echo_ref2_data_out <= act_q[1] ? pick(src_q[1], path_sample_in) : '0;
      end
    end
  end

  // ----------------------------------------
  // headphone and speaker outputs
  // ----------------------------------------
  // mono: right is the negated left, differential swing doubles for +6 dB
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hp_left_out <= '0;
      hp_right_out <= '0;
      spk_left_out <= '0;
      spk_right_out <= '0;
    end else if (sample_strobe_in) begin
      for (int k = 0; k < 3; k++) begin
        hp_left_out[k] <= path_sample_in[2*k];
        hp_right_out[k] <= mono_q[k] ? SAMPLE_W'(-path_sample_in[2*k]) : path_sample_in[2*k+1];
      end
      spk_left_out <= path_sample_in[6];
      spk_right_out <= path_sample_in[7];
    end
  end

  // static control outputs
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hp_differential_out <= 3'h0;
      gate_threshold_out <= 3'h0;
      detect_pin_set_sel_out <= 1'b0;
      echo_ref1_active_out <= 1'b0;
      echo_ref2_active_out <= 1'b0;
      underclk_err_out <= 1'b0;
    end else begin
      hp_differential_out <= mono_q;
      gate_threshold_out <= gate_thr_q;
      detect_pin_set_sel_out <= det_sel_q;
      echo_ref1_active_out <= act_q[0];
      echo_ref2_active_out <= act_q[1];
      underclk_err_out <= err_q;
    end
  end

  // ----------------------------------------
  // noise gates
  // ----------------------------------------
  // hold code to cycle count
  always_comb begin
    case (hold_q)
      2'h0: hold_lim = 32'(HOLD0_CYC);
      2'h1: hold_lim = 32'(HOLD1_CYC);
      2'h2: hold_lim = 32'(HOLD2_CYC);
      2'h3: hold_lim = 32'(HOLD3_CYC);
      default: hold_lim = 32'(HOLD0_CYC);
    endcase
  end

  logic [11:0] quiet;          // all selected sources below threshold
  logic [31:0] gcnt_q [12];    // quiet time counters
  for (genvar k = 0; k < 12; k++) begin : g_gate
    assign quiet[k] = gate_on_q & (|gsel_q[k]) & (&(path_below_thr_in | ~gsel_q[k]));

    // source mask, one path selected at reset
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        gsel_q[k] <= 12'(1 << k);
      end else if (wr && idx == 12'(`OLMC_IDX_GSEL_BASE + k * `OLMC_IDX_GSEL_STEP)) begin
        gsel_q[k] <= pwdata_in[11:0];
      end
    end

    // mute after the hold time of continuous quiet
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        gcnt_q[k] <= 32'h0;
        gate_mute_out[k] <= 1'b0;
      end else if (!quiet[k]) begin
        gcnt_q[k] <= 32'h0;
        gate_mute_out[k] <= 1'b0;
      end else if (gcnt_q[k] >= hold_lim) begin
        gate_mute_out[k] <= 1'b1;
      end else begin
        gcnt_q[k] <= gcnt_q[k] + 32'h1;
      end
    end
  end

  // ----------------------------------------
  // read mux and decode
  // ----------------------------------------
  always_comb begin
    rdata_d = 32'h0;
    hit_d = paddr_in[15:14] == 2'h0 && paddr_in[1:0] == 2'h0;
    case (idx)
      `OLMC_IDX_ACC_DET: rdata_d[`OLMC_BIT_DET_SEL] = det_sel_q;
      `OLMC_IDX_PATH1: rdata_d[`OLMC_BIT_MONO] = mono_q[0];
      `OLMC_IDX_PATH2: rdata_d[`OLMC_BIT_MONO] = mono_q[1];
      `OLMC_IDX_PATH3: rdata_d[`OLMC_BIT_MONO] = mono_q[2];
      `OLMC_IDX_LOOP1: rdata_d[5:0] = {src_q[0], act_q[0], on_q[0]};
      `OLMC_IDX_LOOP2: rdata_d[5:0] = {src_q[1], act_q[1], on_q[1]};
      `OLMC_IDX_GATE_CTRL: rdata_d[5:0] = {hold_q, gate_thr_q, gate_on_q};
      `OLMC_IDX_STATUS: rdata_d[`OLMC_BIT_UNDERCLK] = err_q;
      default: begin
        hit_d = 1'b0;
        for (int k = 0; k < 12; k++) begin
          if (idx == 12'(`OLMC_IDX_GSEL_BASE + k * `OLMC_IDX_GSEL_STEP)) begin
            hit_d = paddr_in[15:14] == 2'h0 && paddr_in[1:0] == 2'h0;
            rdata_d[11:0] = gsel_q[k];
          end
        end
      end
    endcase
  end

  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign prdata_out = prdata_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  chk_loop_refuse: assert property (rej[0] |=> !act_q[0] && err_q)
    else $error("refused loopback became active or raised no error");
  chk_loop_other: assert property (rej[0] |=> act_q[1] == $past(act_q[1]))
    else $error("refused loopback disturbed the other path");
  chk_loop_status: assert property (act_q[0] |-> on_q[0])
    else $error("loopback active without request");
  chk_loop_src: assert property (sample_strobe_in && act_q[0] && src_q[0] == 4'h6
    |=> echo_ref1_data_out == spk_left_out)
    else $error("loopback source select wrong");
  chk_reserved_src: assert property (sample_strobe_in && src_q[0] == 4'h5 |=> echo_ref1_data_out == '0)
    else $error("reserved source not silent");
  chk_mono_invert: assert property (sample_strobe_in && mono_q[0]
    |=> hp_right_out[0] == SAMPLE_W'(-hp_left_out[0]))
    else $error("mono right is not inverted left");
  chk_gate_off: assert property (!gate_on_q |=> gate_mute_out == 12'h0)
    else $error("gate muted while disabled");
  chk_gate_all: assert property (!quiet[0] |=> !gate_mute_out[0])
    else $error("gate muted with a source above threshold");
  chk_gate_hold: assert property ($rose(gate_mute_out[0]) |-> $past(gcnt_q[0]) >= $past(hold_lim))
    else $error("gate muted before hold time");
  chk_apb_ready: assert property (acc_ph |=> pready_out ##1 !pready_out)
    else $error("apb ready not a single pulse after one wait");
endmodule

// [tb/olmc_far_model.sv]
// olmc_far_model.sv: output-path source on the far side, one strobe per frame
// assumes: runs on the block's clock; the bench sets the frame length
`timescale 1ns/1ps
module olmc_far_model #(
  parameter int SAMPLE_W = 24 // sample width
) (
  input wire logic clk_in, // system clock
  input wire logic rst_b_in, // async reset, active low
  input wire logic [7:0] period_in, // clocks per frame
  output logic [11:0][SAMPLE_W-1:0] sample_out, // post-volume samples 1L..6R
  output logic strobe_out // one pulse per frame
);
  // ----------------------------------------
  // frame timer
  // ----------------------------------------
  int cnt_q; // clocks since last strobe
  int seed = 32'h1f58bf93; // fixed seed, repeatable samples
  // new samples land with the strobe and hold for the whole frame
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q <= 0;
      strobe_out <= 1'b0;
      sample_out <= '0;
    end else if (cnt_q >= int'(period_in) - 1) begin
      cnt_q <= 0;
      strobe_out <= 1'b1;
      for (int i = 0; i < 12; i++) begin
        sample_out[i] <= SAMPLE_W'($random(seed));
      end
    end else begin
      cnt_q <= cnt_q + 1;
      strobe_out <= 1'b0;
    end
  end
endmodule

// [tb/test_output_path_loopback_mono_ctrl.sv]
// test_output_path_loopback_mono_ctrl.sv: self-checking bench for the loopback/mono block
// assumes: olmc_top and olmc_far_model compiled first; header found by bare name
`timescale 1ns/1ps
`include "olmc_consts.svh"
module test_output_path_loopback_mono_ctrl;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int SW = 24; // sample width
  localparam logic [11:0] REGS [8] = '{`OLMC_IDX_ACC_DET, `OLMC_IDX_PATH1, `OLMC_IDX_PATH2,
    `OLMC_IDX_PATH3, `OLMC_IDX_LOOP1, `OLMC_IDX_LOOP2, `OLMC_IDX_GATE_CTRL, `OLMC_IDX_STATUS};
  logic core_clk_in = 1'b0; // 250 MHz clock
  logic rst_b_in = 1'b0; // active-low reset
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0; // apb controls
  logic [15:0] paddr = '0; // apb byte address
  logic [31:0] pwdata = '0, prdata, rd; // apb data, last read
  logic pready, pslverr, er; // apb answer, last error
  logic [11:0][SW-1:0] samp; // far-side samples
  logic strobe, estr, dsel, act1, act2, uerr; // strobes and flags
  logic [11:0] below = '0, mute; // gate inputs and outputs
  logic [7:0] period = 8'h0a; // frame length in clocks
  logic [SW-1:0] e1, e2, spkl, spkr; // loopback and speaker streams
  logic [2:0][SW-1:0] hpl, hpr; // headphone streams
  logic [2:0] diff, thr, tc; // mono flags, threshold, random code
  logic [3:0] c2; // random loopback two source
  logic m; // mono setting under test
  int err_total = 0, checks = 0; // mismatch and comparison counts
  int seed = 32'h1f58bf93; // fixed seed
  // free-running clock, 4 ns period, never stopped so the speaker feed always has its clock
  always #2 core_clk_in = ~core_clk_in;
  olmc_top #(.SAMPLE_W(SW), .LOOP_MIN_CYCLES(8), .HOLD0_CYC(4), .HOLD1_CYC(8), .HOLD2_CYC(12),
    .HOLD3_CYC(16)) uut (
    .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready),
    .pslverr_out(pslverr), .prdata_out(prdata), .path_sample_in(samp), .sample_strobe_in(strobe),
    .path_below_thr_in(below), .echo_ref1_data_out(e1), .echo_ref2_data_out(e2),
    .echo_ref_strobe_out(estr), .hp_left_out(hpl), .hp_right_out(hpr), .spk_left_out(spkl),
    .spk_right_out(spkr), .gate_mute_out(mute), .hp_differential_out(diff),
    .gate_threshold_out(thr), .detect_pin_set_sel_out(dsel), .echo_ref1_active_out(act1),
    .echo_ref2_active_out(act2), .underclk_err_out(uerr));
  olmc_far_model #(.SAMPLE_W(SW)) far (.clk_in(core_clk_in), .rst_b_in(rst_b_in),
    .period_in(period), .sample_out(samp), .strobe_out(strobe));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // expected loopback sample: reserved codes give silence
  function automatic logic [SW-1:0] pick(input logic [3:0] c, input logic [11:0][SW-1:0] s);
    if (c == 4'h5 || c > 4'hb) begin
      return '0;
    end
    return s[c];
  endfunction
  // prints counts and verdict, ends the run
  task automatic give_verdict();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // compares one result, counts it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // a bounded wait ran out
  task automatic hang(input string what);
    err_total++;
    $display("FAIL %0t timeout %s", $time, what);
    give_verdict();
  endtask
  // one apb transfer: setup, access, hold until pready
  task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] wd);
    int n = 0;
    @(posedge core_clk_in);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge core_clk_in);
    pen <= 1'b1;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) hang("apb");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // reads a register and compares it
  task automatic rd_chk(input logic [11:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp, "register read");
  endtask
  // waits for the loopback frame strobe
  task automatic wait_estr();
    int n = 0;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (estr !== 1'b1 && n < 40);
    if (estr !== 1'b1) hang("echo strobe");
  endtask
  task automatic done(input string name);
    $display("test %s done", name);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    // reset values, gate selects, unmapped place
    foreach (REGS[i]) rd_chk(REGS[i], 32'h0);
    for (int k = 0; k < 12; k++) rd_chk(`OLMC_IDX_GSEL_BASE + 12'(4 * k), 32'h1 << k);
    apb(1'b0, 12'h400, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    done("reset");
    // refused enable leaves the running loopback alone
    apb(1'b1, `OLMC_IDX_LOOP2, 32'h0d);
    rd_chk(`OLMC_IDX_LOOP2, 32'h0f);
    period <= 8'h06;
    repeat (30) @(posedge core_clk_in);
    apb(1'b1, `OLMC_IDX_LOOP1, 32'h01);
    rd_chk(`OLMC_IDX_LOOP1, 32'h01);
    rd_chk(`OLMC_IDX_LOOP2, 32'h0f);
    rd_chk(`OLMC_IDX_STATUS, 32'h01);
    chk({29'h0, act1, act2, uerr}, 32'h3, "active and error flags");
    apb(1'b1, `OLMC_IDX_STATUS, 32'h01);
    rd_chk(`OLMC_IDX_STATUS, 32'h0);
    period <= 8'h0a;
    repeat (30) @(posedge core_clk_in);
    apb(1'b1, `OLMC_IDX_LOOP1, 32'h02);
    rd_chk(`OLMC_IDX_LOOP1, 32'h0);
    done("underclock");
    // every source code on loopback one, random code on loopback two
    for (int c = 0; c < 16; c++) begin
      c2 = 4'($random(seed));
      apb(1'b1, `OLMC_IDX_LOOP1, {26'h0, 4'(c), 2'b01});
      apb(1'b1, `OLMC_IDX_LOOP2, {26'h0, c2, 2'b01});
      wait_estr();
      wait_estr();
      chk({8'h0, e1}, {8'h0, pick(4'(c), samp)}, "echo one");
      chk({8'h0, e2}, {8'h0, pick(c2, samp)}, "echo two");
    end
    done("loopback");
    // mono mode per headphone path, detect pin set, speaker feed
    for (int k = 0; k < 6; k++) begin
      m = 1'(k);
      tc = 3'($random(seed));
      apb(1'b1, `OLMC_IDX_PATH1 + 12'(8 * (k / 2)), {19'h0, m, 12'h0});
      apb(1'b1, `OLMC_IDX_ACC_DET, {18'h0, tc[0], 13'h0});
      wait_estr();
      repeat (2) @(posedge core_clk_in);
      chk({8'h0, hpl[k/2]}, {8'h0, samp[2*(k/2)]}, "headphone left");
      chk({8'h0, hpr[k/2]}, {8'h0, m ? -samp[2*(k/2)] : samp[2*(k/2)+1]}, "headphone right");
      chk({31'h0, diff[k/2]}, {31'h0, m}, "mono flag");
      chk({8'h0, spkl}, {8'h0, samp[6]}, "speaker left");
      chk({8'h0, spkr}, {8'h0, samp[7]}, "speaker right");
      chk({31'h0, dsel}, {31'h0, tc[0]}, "detect pin set");
    end
    done("mono");
    // gate hold delay for every code
    for (int h = 0; h < 4; h++) begin
      tc = 3'($random(seed));
      below <= 12'h000;
      apb(1'b1, `OLMC_IDX_GATE_CTRL, {26'h0, 2'(h), tc, 1'b1});
      @(posedge core_clk_in);
      below <= 12'h001;
      // first edge after the hold count reaches its limit, mute not yet visible, then the next one
      repeat (4 * h + 5) @(posedge core_clk_in);
      chk({20'h0, mute}, 32'h0, "gate early");
      @(posedge core_clk_in);
      chk({20'h0, mute}, 32'h1, "gate muted");
      chk({29'h0, thr}, {29'h0, tc}, "threshold code");
    end
    apb(1'b1, `OLMC_IDX_GSEL_BASE, 32'h003);
    repeat (30) @(posedge core_clk_in);
    chk({20'h0, mute}, 32'h0, "gate partial");
    below <= 12'h003;
    repeat (25) @(posedge core_clk_in);
    chk({20'h0, mute}, 32'h3, "gate all quiet");
    apb(1'b1, `OLMC_IDX_GATE_CTRL, 32'h0);
    repeat (4) @(posedge core_clk_in);
    chk({20'h0, mute}, 32'h0, "gate off");
    done("gate");
    give_verdict();
  end
endmodule
